// file: fosc_pkg.sv
package fosc_pkg;

  // ************************************************************
  // Register map and field layout
  // ************************************************************
  localparam int unsigned REG_WIDTH = 16;
  localparam logic [3:0] ADDR_FAULT_STATE = 4'h3;
  localparam logic [3:0] ADDR_PROT_ENABLE = 4'h4;
  localparam int unsigned POS_UV_STATE = 15;
  localparam int unsigned POS_OV_STATE = 14;
  localparam int unsigned POS_PWM_STATE = 13;
  localparam int unsigned POS_STP_STATE = 11;
  localparam int unsigned POS_RSVD = 10;
  localparam int unsigned POS_SPI_STATE = 8;
  localparam int unsigned POS_REG_STATE = 7;
  localparam int unsigned POS_LINK_STATE = 6;
  localparam int unsigned POS_ODD_EN = 5;
  localparam int unsigned POS_EVEN_EN = 4;
  localparam int unsigned POS_CRC_STATE = 3;
  localparam int unsigned POS_BIAS_SEL = 0;
  localparam logic [15:0] RESET_FAULT_STATE = 16'h0200;
  localparam logic [15:0] RESET_PROT_ENABLE = 16'h0934;
  localparam logic RESET_GATE_DOWN = 1'b1;

  // ************************************************************
  // Two-bit output action codes
  // ************************************************************
  localparam logic [1:0] ACT_LOW = 2'h0;
  localparam logic [1:0] ACT_HIGH = 2'h1;

  typedef struct packed {
    logic [15:0] fault_state_q;
    logic [15:0] prot_enable_q;
    logic crc_flag_q;
    logic gate_up_q;
    logic gate_down_q;
    logic odd_en_q;
    logic even_en_q;
    logic [2:0] bias_q;
    logic [15:0] rdata_q;
  } fosc_state_type;

endpackage

// file: fosc_bank.sv
`timescale 1ns/1ps
// Notes on behaviour
// - A primary undervoltage fault pulls the gate low when its state bit is 0, else no action.
// - A primary overvoltage fault pulls the gate low when its state bit is 0, else no action.
// - A PWM check fault pulls the gate low when its state bit is 0, else no action.
// - The shoot-through field gives low on 0, high on 1, no action on 3, reserved 2, reset 0.
// - Writing 1 to reserved bit 10 sets the configuration checksum fault flag and stores the value.
// - The serial fault field gives low on 0, high on 1, no action on 2 or 3, reset 2.
// - An internal regulator fault pulls the gate low when its state bit is 0, else no action.
// - An internal link fault pulls the gate low when its state bit is 0, else no action.
// - The odd-input current source enable follows bit 5, reset 0.
// - The even-input current source enable follows bit 4, reset 0.
// - A configuration checksum fault pulls the gate low when its state bit is 0, else no action.
// - The bias select field enables inputs one, three and five as a bitmap.
// - A selected bias current is only applied while the odd-input source enable is 1.
module fosc_bank
(
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic WR_EN,
  input wire logic RD_EN,
  input wire logic [3:0] ADDR,
  input wire logic [fosc_pkg::REG_WIDTH-1:0] WDATA,
  input wire logic CRC_CLEAR,
  input wire logic CMD_IN,
  input wire logic UV_FAULT,
  input wire logic OV_FAULT,
  input wire logic PWM_FAULT,
  input wire logic STP_FAULT,
  input wire logic SPI_FAULT,
  input wire logic REG_FAULT,
  input wire logic LINK_FAULT,
  input wire logic CRC_FAULT,
  output logic [fosc_pkg::REG_WIDTH-1:0] RDATA,
  output logic CONFIG_CHECKSUM_FAULT_FLAG,
  output logic GATE_PULLUP_OUTPUT,
  output logic GATE_PULLDOWN_OUTPUT,
  output logic ODD_INPUT_SOURCE_ENABLE,
  output logic EVEN_INPUT_SOURCE_ENABLE,
  output logic [2:0] BIAS_CURRENT_ENABLE,
  output logic [fosc_pkg::REG_WIDTH-1:0] PROT_ENABLE_CONFIG
);
  import fosc_pkg::*;

  // ************************************************************
  // Local sizes
  // ************************************************************
  // Faults whose state field is a single bit: 0 pulls low, 1 is no action
  localparam int unsigned NUM_SINGLE = 6;
  localparam int unsigned ACT_WIDTH = 2;
  localparam int unsigned BIAS_WIDTH = 3;

  // ************************************************************
  // Decode helpers
  // ************************************************************
  // One strobe-and-address match shared by both register write paths
  function automatic logic addr_hit
  (
    input logic strobe,
    input logic [3:0] sel,
    input logic [3:0] target
  );
    addr_hit = strobe && (sel == target);
  endfunction

  // Two-bit codes: bit 0 of the result asks for low, bit 1 for high
  function automatic logic [ACT_WIDTH-1:0] action_decode
  (
    input logic [ACT_WIDTH-1:0] code
  );
    logic [ACT_WIDTH-1:0] req;
    req = 2'h0;
    case (code)
      ACT_LOW:
      begin
        req = 2'h1;
      end
      ACT_HIGH:
      begin
        req = 2'h2;
      end
      default:
      begin
        // Reserved codes act as no action rather than guessing a level
        req = 2'h0;
      end
    endcase
    action_decode = req;
  endfunction

  // ************************************************************
  // Declarations
  // ************************************************************
  fosc_state_type s_q;
  fosc_state_type s_d;
  logic [REG_WIDTH-1:0] cfg;
  logic [NUM_SINGLE-1:0] single_flt;
  logic [NUM_SINGLE-1:0] single_cfg;
  wire logic [NUM_SINGLE-1:0] single_low;
  logic [ACT_WIDTH-1:0] stp_req;
  logic [ACT_WIDTH-1:0] spi_req;
  logic force_low;
  logic force_high;
  logic wr_fault_state;
  logic wr_prot_enable;

  // ************************************************************
  // Fault collection
  // ************************************************************
  // Fault inputs arrive already masked and on this clock, so no synchroniser
  assign cfg = s_q.fault_state_q;

  assign single_flt =
  {
    UV_FAULT,
    OV_FAULT,
    PWM_FAULT,
    REG_FAULT,
    LINK_FAULT,
    // The sticky flag keeps acting like a checksum fault until cleared
    CRC_FAULT | s_q.crc_flag_q
  };

  assign single_cfg =
  {
    cfg[POS_UV_STATE],
    cfg[POS_OV_STATE],
    cfg[POS_PWM_STATE],
    cfg[POS_REG_STATE],
    cfg[POS_LINK_STATE],
    cfg[POS_CRC_STATE]
  };

  // ************************************************************
  // Fault resolution
  // ************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SINGLE; gi = gi + 1)
    begin : g_single
      assign single_low[gi] = single_flt[gi] & ~single_cfg[gi];
    end
  endgenerate

  assign stp_req = STP_FAULT ? action_decode(cfg[POS_STP_STATE+:2]) : 2'h0;
  assign spi_req = SPI_FAULT ? action_decode(cfg[POS_SPI_STATE+:2]) : 2'h0;

  // Low beats high: a conflict between faults must never turn the switch on
  assign force_low = (|single_low) | stp_req[0] | spi_req[0];
  assign force_high = stp_req[1] | spi_req[1];

  // ************************************************************
  // Write decode
  // ************************************************************
  assign wr_fault_state = addr_hit(WR_EN, ADDR, ADDR_FAULT_STATE);
  assign wr_prot_enable = addr_hit(WR_EN, ADDR, ADDR_PROT_ENABLE);

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb
  begin
    s_d = s_q;
    if (wr_fault_state)
    begin
      s_d.fault_state_q = WDATA;
    end
    if (wr_prot_enable)
    begin
      s_d.prot_enable_q = WDATA;
    end
    // Set wins over a simultaneous clear, so a bad write is never lost
    if (CRC_CLEAR)
    begin
      s_d.crc_flag_q = 1'b0;
    end
    if (wr_fault_state && WDATA[POS_RSVD])
    begin
      s_d.crc_flag_q = 1'b1;
    end
    if (force_low)
    begin
      s_d.gate_up_q = 1'b0;
    end
    else if (force_high)
    begin
      s_d.gate_up_q = 1'b1;
    end
    else
    begin
      s_d.gate_up_q = CMD_IN;
    end
    s_d.gate_down_q = ~s_d.gate_up_q;
    // Enables follow the incoming word so they settle with the register
    s_d.odd_en_q = s_d.fault_state_q[POS_ODD_EN];
    s_d.even_en_q = s_d.fault_state_q[POS_EVEN_EN];
    s_d.bias_q = s_d.fault_state_q[POS_BIAS_SEL+:BIAS_WIDTH]
      & {BIAS_WIDTH{s_d.fault_state_q[POS_ODD_EN]}};
    if (RD_EN)
    begin
      // A read in the same cycle as a write returns the old word
      case (ADDR)
        ADDR_FAULT_STATE:
        begin
          s_d.rdata_q = s_q.fault_state_q;
        end
        ADDR_PROT_ENABLE:
        begin
          s_d.rdata_q = s_q.prot_enable_q;
        end
        default:
        begin
          s_d.rdata_q = '0;
        end
      endcase
    end
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      s_q <= '0;
      s_q.fault_state_q <= RESET_FAULT_STATE;
      s_q.prot_enable_q <= RESET_PROT_ENABLE;
      s_q.gate_down_q <= RESET_GATE_DOWN;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign RDATA = s_q.rdata_q;
  assign CONFIG_CHECKSUM_FAULT_FLAG = s_q.crc_flag_q;
  assign GATE_PULLUP_OUTPUT = s_q.gate_up_q;
  assign GATE_PULLDOWN_OUTPUT = s_q.gate_down_q;
  assign ODD_INPUT_SOURCE_ENABLE = s_q.odd_en_q;
  assign EVEN_INPUT_SOURCE_ENABLE = s_q.even_en_q;
  assign BIAS_CURRENT_ENABLE = s_q.bias_q;
  assign PROT_ENABLE_CONFIG = s_q.prot_enable_q;

endmodule // fosc_bank

// file: fosc_bank_assertions.sv
`timescale 1ns/1ps
module fosc_bank_assertions
(
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic WR_EN,
  input wire logic UV_FAULT,
  input wire logic OV_FAULT,
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic CONFIG_CHECKSUM_FAULT_FLAG,
  input wire logic GATE_PULLUP_OUTPUT,
  input wire logic GATE_PULLDOWN_OUTPUT,
  input wire logic ODD_INPUT_SOURCE_ENABLE,
  input wire logic EVEN_INPUT_SOURCE_ENABLE,
  input wire logic [2:0] BIAS_CURRENT_ENABLE
);
  // Shadow of the fault-state word, so gate checks know the active codes
  logic [15:0] cfg_q;
  logic wr3;
  assign wr3 = WR_EN && ADDR == 4'h3;
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
      cfg_q <= 16'h0200;
    else if (wr3)
      cfg_q <= WDATA;
  end
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  sequence cfg_write; wr3; endsequence
  a_rsvd_flag: assert property (cfg_write ##0 WDATA[10] |=> CONFIG_CHECKSUM_FAULT_FLAG)
    else $error("flag not set");
  a_odd_follow: assert property (cfg_write |=> ODD_INPUT_SOURCE_ENABLE == $past(WDATA[5]))
    else $error("odd enable wrong");
  a_even_follow: assert property (cfg_write |=> EVEN_INPUT_SOURCE_ENABLE == $past(WDATA[4]))
    else $error("even enable wrong");
  a_bias_map: assert property (cfg_write |=> BIAS_CURRENT_ENABLE ==
    ($past(WDATA[2:0]) & {3{$past(WDATA[5])}})) else $error("bias wrong");
  a_bias_gate: assert property (BIAS_CURRENT_ENABLE != 3'h0 |-> ODD_INPUT_SOURCE_ENABLE)
    else $error("bias without source");
  a_gate_compl: assert property (GATE_PULLUP_OUTPUT != GATE_PULLDOWN_OUTPUT)
    else $error("gate not complementary");
  a_uv_low: assert property (UV_FAULT && !cfg_q[15] |=> !GATE_PULLUP_OUTPUT)
    else $error("uv not low");
  a_ov_low: assert property (OV_FAULT && !cfg_q[14] |=> !GATE_PULLUP_OUTPUT)
    else $error("ov not low");
  a_crc_low: assert property (CONFIG_CHECKSUM_FAULT_FLAG && !cfg_q[3] |=>
    !GATE_PULLUP_OUTPUT) else $error("crc not low");
endmodule // fosc_bank_assertions

// file: fosc_bank_tb.sv
`timescale 1ns/1ps
module fosc_bank_tb;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, clr = 0, cmd = 0;
  logic [3:0] addr = 0;
  logic [15:0] wd = 0, rdat, prot;
  logic [7:0] flt = 0;
  logic flag, up, dn, odd, even;
  logic [2:0] bias;
  int num_errors = 0, n_tests = 0, cyc = 0;
  always #2.5 clk = ~clk;
  fosc_bank fosc_bank_i (.REF_CLK(clk), .RST_N(rst_n), .WR_EN(wr), .RD_EN(rd), .ADDR(addr),
    .WDATA(wd), .CRC_CLEAR(clr), .CMD_IN(cmd), .UV_FAULT(flt[0]), .OV_FAULT(flt[1]),
    .PWM_FAULT(flt[2]), .STP_FAULT(flt[3]), .SPI_FAULT(flt[4]), .REG_FAULT(flt[5]),
    .LINK_FAULT(flt[6]), .CRC_FAULT(flt[7]), .RDATA(rdat), .CONFIG_CHECKSUM_FAULT_FLAG(flag),
    .GATE_PULLUP_OUTPUT(up), .GATE_PULLDOWN_OUTPUT(dn), .ODD_INPUT_SOURCE_ENABLE(odd),
    .EVEN_INPUT_SOURCE_ENABLE(even), .BIAS_CURRENT_ENABLE(bias), .PROT_ENABLE_CONFIG(prot));
  task chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e)
    begin
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
      num_errors++;
    end
  endtask
  task wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk) {wr, addr, wd} <= {1'b1, a, d};
    @(posedge clk) wr <= 0;
    #1;
  endtask
  task rd_reg(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk) {rd, addr} <= {1'b1, a};
    @(posedge clk) rd <= 0;
    #1 chk(rdat, e);
  endtask
  task gate(input logic [7:0] f, input logic c, input logic e);
    @(posedge clk) {flt, cmd} <= {f, c};
    @(posedge clk);
    #1 chk({up, dn}, {e, !e});
  endtask
  task wrap_up;
    if (num_errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Cut a hang short well beyond the roughly 110 cycles the run needs
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      num_errors++;
      wrap_up;
    end
  end
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1;
    rd_reg(4'h3, 16'h0200);
    rd_reg(4'h4, 16'h0934);
    gate(8'h10, 1, 1);
    wr_reg(4'h3, 16'h0000);
    for (int i = 0; i < 8; i++) gate(8'h01 << i, 1, 0);
    wr_reg(4'h3, 16'hFBC8);
    for (int i = 0; i < 8; i++) gate(8'h01 << i, 1, 1);
    for (int i = 0; i < 8; i++) gate(8'h01 << i, 0, 0);
    wr_reg(4'h3, 16'h0900);
    gate(8'h08, 0, 1);
    gate(8'h10, 0, 1);
    wr_reg(4'h3, 16'h1000);
    gate(8'h08, 1, 1);
    gate(8'h08, 0, 0);
    wr_reg(4'h3, 16'h0420);
    chk({flag, odd, bias}, 16'h0018);
    rd_reg(4'h3, 16'h0420);
    gate(8'h00, 1, 0);
    @(posedge clk) clr <= 1;
    @(posedge clk) clr <= 0;
    #1 chk(flag, 16'h0000);
    gate(8'h00, 1, 1);
    // Write of the reserved bit and a clear in one cycle: the set must win
    @(posedge clk) {wr, addr, wd, clr} <= {1'b1, 4'h3, 16'h0400, 1'b1};
    @(posedge clk) {wr, clr} <= 2'b00;
    #1 chk(flag, 16'h0001);
    @(posedge clk) clr <= 1;
    @(posedge clk) clr <= 0;
    wr_reg(4'h3, 16'h0007);
    chk({odd, even, bias}, 16'h0000);
    wr_reg(4'h3, 16'h0025);
    chk({odd, even, bias}, 16'h0015);
    wr_reg(4'h3, 16'h0010);
    chk({odd, even, bias}, 16'h0008);
    wr_reg(4'h5, 16'hFFFF);
    rd_reg(4'h5, 16'h0000);
    rd_reg(4'h3, 16'h0010);
    wr_reg(4'h4, 16'h1234);
    rd_reg(4'h4, 16'h1234);
    chk(prot, 16'h1234);
    wrap_up;
  end
endmodule // fosc_bank_tb
bind fosc_bank fosc_bank_assertions fosc_bank_assertions_i (.REF_CLK(REF_CLK), .RST_N(RST_N),
  .WR_EN(WR_EN), .UV_FAULT(UV_FAULT), .OV_FAULT(OV_FAULT), .ADDR(ADDR), .WDATA(WDATA),
  .CONFIG_CHECKSUM_FAULT_FLAG(CONFIG_CHECKSUM_FAULT_FLAG),
  .GATE_PULLUP_OUTPUT(GATE_PULLUP_OUTPUT), .GATE_PULLDOWN_OUTPUT(GATE_PULLDOWN_OUTPUT),
  .ODD_INPUT_SOURCE_ENABLE(ODD_INPUT_SOURCE_ENABLE),
  .EVEN_INPUT_SOURCE_ENABLE(EVEN_INPUT_SOURCE_ENABLE), .BIAS_CURRENT_ENABLE(BIAS_CURRENT_ENABLE));
